// *** core/tsc_pkg.sv ***
package tsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] TSC_OFF_MODE   = 8'h00;
  localparam logic [7:0] TSC_OFF_CMP    = 8'h04;
  localparam logic [7:0] TSC_OFF_OSTYLE = 8'h08;
  localparam logic [7:0] TSC_OFF_OUTCTL = 8'h0c;
  localparam logic [7:0] TSC_OFF_CMD    = 8'h10;
  localparam logic [7:0] TSC_OFF_STATUS = 8'h14;
  localparam logic [7:0] TSC_OFF_CAPT   = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register fields
  localparam int unsigned TSC_CKS_HI   = 15;
  localparam int unsigned TSC_CKS_LO   = 14;
  localparam int unsigned TSC_CCS      = 12;
  localparam int unsigned TSC_SPLIT    = 11;
  localparam int unsigned TSC_STS_HI   = 10;
  localparam int unsigned TSC_STS_LO   = 8;
  localparam int unsigned TSC_MD_HI    = 3;
  localparam int unsigned TSC_MD_LO    = 1;
  localparam int unsigned TSC_MD0      = 0;
  localparam logic [15:0] TSC_MODE_WMASK = 16'hdf0f;

  // Output style register: this channel's bit
  localparam int unsigned TSC_OSTYLE_BIT   = 3;
  localparam logic [15:0] TSC_OSTYLE_WMASK = 16'h00fe;

  // Output control register fields
  localparam int unsigned TSC_OC_ENABLE = 0;
  localparam int unsigned TSC_OC_POL    = 1;
  localparam int unsigned TSC_OC_VALUE  = 2;

  // Command register fields
  localparam int unsigned TSC_CMD_START = 0;
  localparam int unsigned TSC_CMD_STOP  = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] TSC_MODE_RST   = 16'h0000;
  localparam logic [15:0] TSC_CMP_RST    = 16'h0000;
  localparam logic [15:0] TSC_OSTYLE_RST = 16'h0000;
  localparam logic [15:0] TSC_CNT_RST    = 16'h0000;
  localparam logic [31:0] TSC_RDATA_RST  = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Codes
  localparam logic [2:0] TSC_STS_SW     = 3'h0;
  localparam logic [2:0] TSC_STS_EDGE   = 3'h1;
  localparam logic [2:0] TSC_STS_BOTH   = 3'h2;
  localparam logic [2:0] TSC_STS_MASTER = 3'h4;

  localparam logic [2:0] TSC_MD_INTERVAL = 3'h0;
  localparam logic [2:0] TSC_MD_CAPTURE  = 3'h2;
  localparam logic [2:0] TSC_MD_EVENT    = 3'h3;
  localparam logic [2:0] TSC_MD_ONECOUNT = 3'h4;
  localparam logic [2:0] TSC_MD_CAPONE   = 3'h6;

  localparam logic [1:0] TSC_CK_0 = 2'h0;
  localparam logic [1:0] TSC_CK_2 = 2'h1;
  localparam logic [1:0] TSC_CK_1 = 2'h2;

  localparam logic [15:0] TSC_MASK16 = 16'hffff;
  localparam logic [15:0] TSC_MASK8  = 16'h00ff;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {TSC_OFF, TSC_WAIT, TSC_RUN} tsc_state_t;

  typedef struct packed {
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } tsc_apb_t;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] cmp;
    logic [15:0] ostyle;
    logic        toe;
    logic        tol;
    logic        tov;
  } tsc_regs_t;

  typedef struct packed {
    tsc_state_t  state;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic        irq;
    logic        pin;
  } tsc_core_t;

  typedef struct packed {
    tsc_apb_t  apb;
    tsc_regs_t regs;
    tsc_core_t core;
  } tsc_top_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic rise;
    logic fall;
  } tsc_edge_t;

endpackage

// *** core/tsc_edge.sv ***
`timescale 1ns/1ns
module tsc_edge
  import tsc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Sampling strobe (operating clock tick)
  input  wire logic sample,
  // Pin and edges
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);

  tsc_edge_t s_r;
  tsc_edge_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (ce) begin
      s_nxt.sync1 = pin_in;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.rise  = 1'b0;
      s_nxt.fall  = 1'b0;
      if (sample) begin
        s_nxt.last = s_r.sync2;
        s_nxt.rise = s_r.sync2 & ~s_r.last;
        s_nxt.fall = ~s_r.sync2 & s_r.last;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rise = s_r.rise;
  assign fall = s_r.fall;

endmodule

// *** core/tsc_channel.sv ***
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Function
// - Bits 15:14 pick prescaler clock 0/2/1/3
// - Clocks 2 and 3 only on channels 1, 3
// - Bit 12 picks operating clock or pin edge
// - Edge detector on operating clock, counter on count clock
// - Bit 11 selects 16-bit or 8-bit counting
// - Bits 10:8 pick start trigger source
// - Bits 3:1 pick mode and count direction
// - Bit 0 gives start interrupt and output change
// - One-count: bit 0 enables retrigger with interrupt
// - Capture one-count: no start irq, no retrigger
// - One-count pulse lasts compare value count clocks
// - Style bit 0: output toggles on own irq
// - Style bit 1: master irq sets, slave resets
// - Interval period is compare value plus one
// - Output disabled: software bit drives pin
// - Polarity bit 1 inverts the pin
module tsc_channel
  import tsc_pkg::*;
#(
  parameter int unsigned CH_NUM = 3,
  parameter int unsigned AW     = 8
) (
  // Clock, reset, enable
  input  wire logic          CLK_SYS,
  input  wire logic          RESETN,
  input  wire logic          CE,
  // APB slave
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [AW-1:0] PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic               PREADY,
  output logic [31:0]        PRDATA,
  output logic               PSLVERR,
  // Timer unit links
  input  wire logic [3:0]    PRESC_TICK,
  input  wire logic          MASTER_IRQ,
  input  wire logic          SLAVE_IRQ,
  // Channel pins
  input  wire logic          CH_PIN_IN,
  output logic               CH_IRQ,
  output logic               CH_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [7:0]    off);
    hit = (a == AW'(off));
  endfunction

  function automatic logic op_tick(input logic [1:0] cks,
                                   input logic [3:0] t);
    logic wide;
    wide = (CH_NUM == 1) || (CH_NUM == 3);
    case (cks)
      TSC_CK_0: op_tick = t[0];
      TSC_CK_2: op_tick = wide ? t[2] : t[0];
      TSC_CK_1: op_tick = t[1];
      default:  op_tick = wide ? t[3] : t[1];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  tsc_top_t    s_r;
  tsc_top_t    s_nxt;
  logic        optick;
  logic        pin_rise;
  logic        pin_fall;
  logic [1:0]  cks;
  logic        ccs;
  logic        split;
  logic [2:0]  sts;
  logic [2:0]  md;
  logic        md0;

  assign cks   = s_r.regs.mode[TSC_CKS_HI:TSC_CKS_LO];
  assign ccs   = s_r.regs.mode[TSC_CCS];
  assign split = s_r.regs.mode[TSC_SPLIT];
  assign sts   = s_r.regs.mode[TSC_STS_HI:TSC_STS_LO];
  assign md    = s_r.regs.mode[TSC_MD_HI:TSC_MD_LO];
  assign md0   = s_r.regs.mode[TSC_MD0];

  assign optick = op_tick(cks, PRESC_TICK);

  ////////////////////////////////////////////////////////////////////////////
  // Pin edge detector, sampled on the operating clock

  tsc_edge u_edge (
    .clk    (CLK_SYS),
    .rst_n  (RESETN),
    .ce     (CE),
    .sample (optick),
    .pin_in (CH_PIN_IN),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic        sw_start;
  logic        sw_stop;
  logic        cnt_tick;
  logic        trig;
  logic        irq;
  logic [15:0] msk;
  logic [15:0] cmpv;
  logic [31:0] rmux;

  always_comb begin
    s_nxt    = s_r;
    setup    = PSEL & ~PENABLE;
    wr_acc   = PSEL & PENABLE & PWRITE & s_r.apb.ready;
    mapped   = hit(PADDR, TSC_OFF_MODE) | hit(PADDR, TSC_OFF_CMP) |
               hit(PADDR, TSC_OFF_OSTYLE) | hit(PADDR, TSC_OFF_OUTCTL) |
               hit(PADDR, TSC_OFF_CMD) | hit(PADDR, TSC_OFF_STATUS) |
               hit(PADDR, TSC_OFF_CAPT);
    sw_start = 1'b0;
    sw_stop  = 1'b0;
    irq      = 1'b0;
    rmux     = TSC_RDATA_RST;
    msk      = split ? TSC_MASK8 : TSC_MASK16;
    cmpv     = s_r.regs.cmp & msk;
    cnt_tick = ccs ? pin_rise : optick;
    if (hit(PADDR, TSC_OFF_MODE)) begin
      rmux = {16'h0000, s_r.regs.mode};
    end else if (hit(PADDR, TSC_OFF_CMP)) begin
      rmux = {16'h0000, s_r.regs.cmp};
    end else if (hit(PADDR, TSC_OFF_OSTYLE)) begin
      rmux = {16'h0000, s_r.regs.ostyle};
    end else if (hit(PADDR, TSC_OFF_OUTCTL)) begin
      rmux = {29'h0000_0000, s_r.regs.tov, s_r.regs.tol, s_r.regs.toe};
    end else if (hit(PADDR, TSC_OFF_STATUS)) begin
      rmux = {s_r.core.cnt, 14'h0000, s_r.core.state == TSC_RUN,
              s_r.core.state != TSC_OFF};
    end else if (hit(PADDR, TSC_OFF_CAPT)) begin
      rmux = {16'h0000, s_r.core.cap};
    end

    if (CE) begin
      //////////////////////////////////////////////////////////////////////
      // APB: answer in the first access cycle
      s_nxt.apb.ready  = setup & ~s_r.apb.ready;
      s_nxt.apb.slverr = setup & ~mapped;
      if (setup && !PWRITE) begin
        s_nxt.apb.rdata = rmux;
      end
      if (wr_acc) begin
        if (hit(PADDR, TSC_OFF_MODE)) begin
          s_nxt.regs.mode = PWDATA[15:0] & TSC_MODE_WMASK;
        end
        if (hit(PADDR, TSC_OFF_CMP)) begin
          s_nxt.regs.cmp = PWDATA[15:0];
        end
        if (hit(PADDR, TSC_OFF_OSTYLE)) begin
          s_nxt.regs.ostyle = PWDATA[15:0] & TSC_OSTYLE_WMASK;
        end
        if (hit(PADDR, TSC_OFF_OUTCTL)) begin
          s_nxt.regs.toe = PWDATA[TSC_OC_ENABLE];
          s_nxt.regs.tol = PWDATA[TSC_OC_POL];
          if (!s_r.regs.toe) begin
            s_nxt.regs.tov = PWDATA[TSC_OC_VALUE];
          end
        end
        if (hit(PADDR, TSC_OFF_CMD)) begin
          sw_start = PWDATA[TSC_CMD_START];
          sw_stop  = PWDATA[TSC_CMD_STOP];
        end
      end

      //////////////////////////////////////////////////////////////////////
      // Start trigger
      trig = sw_start;
      case (sts)
        TSC_STS_EDGE:   trig = trig | pin_rise;
        TSC_STS_BOTH:   trig = trig | pin_rise | pin_fall;
        TSC_STS_MASTER: trig = trig | MASTER_IRQ;
        default:        trig = trig;
      endcase

      //////////////////////////////////////////////////////////////////////
      // Counter
      case (s_r.core.state)
        TSC_OFF: begin
          if (sw_start) begin
            if (md == TSC_MD_ONECOUNT || md == TSC_MD_CAPONE) begin
              s_nxt.core.state = TSC_WAIT;
            end else begin
              s_nxt.core.state = TSC_RUN;
              s_nxt.core.cnt   = (md == TSC_MD_CAPTURE) ? TSC_CNT_RST
                                                        : cmpv;
              irq = md0;
            end
          end
        end
        TSC_WAIT: begin
          if (trig) begin
            s_nxt.core.state = TSC_RUN;
            s_nxt.core.cnt   = (md == TSC_MD_CAPONE) ? TSC_CNT_RST
                                                     : cmpv;
          end
        end
        TSC_RUN: begin
          case (md)
            TSC_MD_INTERVAL, TSC_MD_EVENT: begin
              if (cnt_tick) begin
                if (s_r.core.cnt == TSC_CNT_RST) begin
                  s_nxt.core.cnt = cmpv;
                  irq            = 1'b1;
                end else begin
                  s_nxt.core.cnt = (s_r.core.cnt - 16'h0001) & msk;
                end
              end
            end
            TSC_MD_CAPTURE: begin
              if (trig && !sw_start) begin
                s_nxt.core.cap = s_r.core.cnt;
                s_nxt.core.cnt = TSC_CNT_RST;
                irq            = 1'b1;
              end else if (cnt_tick) begin
                s_nxt.core.cnt = (s_r.core.cnt + 16'h0001) & msk;
              end
            end
            TSC_MD_ONECOUNT: begin
              if (trig) begin
                if (md0) begin
                  s_nxt.core.cnt = cmpv;
                  irq            = 1'b1;
                end
              end else if (cnt_tick) begin
                if (s_r.core.cnt <= 16'h0001) begin
                  s_nxt.core.state = TSC_WAIT;
                  irq              = 1'b1;
                end else begin
                  s_nxt.core.cnt = (s_r.core.cnt - 16'h0001) & msk;
                end
              end
            end
            TSC_MD_CAPONE: begin
              if (pin_fall) begin
                s_nxt.core.cap   = s_r.core.cnt;
                s_nxt.core.state = TSC_WAIT;
                irq              = 1'b1;
              end else if (cnt_tick) begin
                s_nxt.core.cnt = (s_r.core.cnt + 16'h0001) & msk;
              end
            end
            default: begin
              s_nxt.core.cnt = s_r.core.cnt;
            end
          endcase
        end
        default: begin
          s_nxt.core.state = TSC_OFF;
        end
      endcase
      if (sw_stop) begin
        s_nxt.core.state = TSC_OFF;
      end
      s_nxt.core.irq = irq;

      //////////////////////////////////////////////////////////////////////
      // Output controller
      if (s_r.regs.toe) begin
        if (s_r.regs.ostyle[TSC_OSTYLE_BIT]) begin
          if (MASTER_IRQ) begin
            s_nxt.regs.tov = 1'b1;
          end else if (SLAVE_IRQ) begin
            s_nxt.regs.tov = 1'b0;
          end
        end else if (irq) begin
          s_nxt.regs.tov = ~s_r.regs.tov;
        end
      end
      s_nxt.core.pin = s_nxt.regs.tov ^ s_nxt.regs.tol;
    end else begin
      trig = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      s_r             <= '0;
      s_r.regs.mode   <= TSC_MODE_RST;
      s_r.regs.cmp    <= TSC_CMP_RST;
      s_r.regs.ostyle <= TSC_OSTYLE_RST;
      s_r.core.state  <= TSC_OFF;
      s_r.core.cnt    <= TSC_CNT_RST;
      s_r.apb.rdata   <= TSC_RDATA_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign PREADY  = s_r.apb.ready;
  assign PRDATA  = s_r.apb.rdata;
  assign PSLVERR = s_r.apb.slverr;
  assign CH_IRQ  = s_r.core.irq;
  assign CH_OUT  = s_r.core.pin;

endmodule

// *** dv/tsc_channel_assertions.sv ***
`timescale 1ns/1ns
module tsc_channel_assertions
  import tsc_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  // Channel
  input wire logic        MASTER_IRQ,
  input wire logic        SLAVE_IRQ,
  input wire logic        CH_IRQ,
  input wire logic        CH_OUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence access_s;
    PSEL && PENABLE && PREADY;
  endsequence

  a_ready_after_setup: assert property (setup_s |=> access_s)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_idle_no_ready: assert property (!PSEL |=> !PREADY)
    else $error("ready without select");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_err_read_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("error read data not zero");
  a_rdata_hold: assert property
    ($changed(PRDATA) |-> $past(PSEL && !PENABLE && !PWRITE))
    else $error("read data changed without read");
  a_out_cause: assert property ($changed(CH_OUT) |-> CH_IRQ ||
    $past(CH_IRQ || MASTER_IRQ || SLAVE_IRQ || (PSEL && PENABLE && PWRITE)))
    else $error("output changed without cause");
  a_reset_quiet: assert property
    ($rose(RESETN) |-> !PREADY && !PSLVERR && !CH_IRQ && !CH_OUT)
    else $error("outputs active after reset");
endmodule

bind tsc_channel tsc_channel_assertions tsc_channel_assertions_i (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .MASTER_IRQ(MASTER_IRQ), .SLAVE_IRQ(SLAVE_IRQ), .CH_IRQ(CH_IRQ),
  .CH_OUT(CH_OUT));

// *** dv/tsc_master_model.sv ***
`timescale 1ns/1ns
module tsc_master_model
  import tsc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        go,
  input  wire logic [15:0] period,
  // Unit links
  output logic [3:0]       tick,
  output logic             irq
);
  logic [2:0]  div_r;
  logic [15:0] cnt_r;

  // Prescaler clock i ticks every 2**i cycles
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      tick[i] = ((div_r & 3'((1 << i) - 1)) == 3'h0);
    end
  end

  // Master period is the period input plus one clock cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 3'h0;
      cnt_r <= 16'h0;
      irq   <= 1'b0;
    end else begin
      div_r <= div_r + 3'h1;
      irq   <= go && (cnt_r == 16'h0);
      if (!go || cnt_r == 16'h0) cnt_r <= period;
      else cnt_r <= cnt_r - 16'h1;
    end
  end
endmodule

// *** dv/timer_slave_channel_mode_config_bench.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin \
  check_count++; \
  if ((a) !== (b)) begin \
    bad_count++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); \
  end \
end
module timer_slave_channel_mode_config_bench;
  import tsc_pkg::*;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic        mgo = 0, sirq = 0, pin = 0, ce = 1, o;
  logic        rdy, err, slv, cirq, cout, mirq;
  logic [7:0]  paddr = 8'h0;
  logic [15:0] mper = 16'h0, v;
  logic [31:0] pwdata = 32'h0, prdata, rdat, seed = 32'haeb65c17;
  logic [3:0]  tick;
  int          bad_count = 0, check_count = 0, cyc = 0;
  int          t0, t1, g0, c;

  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  tsc_channel tsc_channel_i (.CLK_SYS(clk), .RESETN(rst_n), .CE(ce),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PREADY(rdy), .PRDATA(prdata), .PSLVERR(slv),
    .PRESC_TICK(tick), .MASTER_IRQ(mirq), .SLAVE_IRQ(sirq),
    .CH_PIN_IN(pin), .CH_IRQ(cirq), .CH_OUT(cout));
  tsc_master_model tsc_master_model_i (.clk(clk), .rst_n(rst_n),
    .go(mgo), .period(mper), .tick(tick), .irq(mirq));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Interval period in cycles for a clock-select code
  function automatic int exp_gap(input logic [15:0] n, input logic [1:0] k);
    return (int'(n) + 1) << {k[0], k[1]};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (rdy === 1'b1) break;
    end
    rdat = prdata;
    err = slv;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n == 20) begin
      bad_count++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic wait_sig(input logic m, output int t);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if ((m ? mirq : cirq) === 1'b1) break;
    end
    t = cyc;
    if (n == 3000) begin
      bad_count++;
      finish_test();
    end
  endtask

  task automatic cnt_irq(input int k, output int n);
    n = 0;
    repeat (k) begin
      @(posedge clk);
      if (cirq === 1'b1) n++;
    end
  endtask

  // Toggle the input pin six times, counting channel interrupts
  task automatic pulse_irqs(output int n);
    int k;
    n = 0;
    repeat (6) begin
      pin <= ~pin;
      cnt_irq(6, k);
      n += k;
    end
  endtask

  task automatic chk_out(input logic e);
    repeat (2) @(posedge clk);
    `CHK(cout, e)
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 24; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      `CHK(rdat, 32'h0)
    end
    apb(1'b0, 8'h1c, 32'h0);
    `CHK({err, rdat}, 33'h1_0000_0000)
    wr(8'h1c, 32'h5);
    `CHK(err, 1'b1)
    repeat (8) begin
      seed = xs(seed);
      v = seed[15:0];
      pin <= seed[31];
      wr(TSC_OFF_MODE, seed);
      apb(1'b0, TSC_OFF_MODE, 32'h0);
      `CHK(rdat, {16'h0, v & TSC_MODE_WMASK})
      wr(TSC_OFF_CMP, {16'h0, seed[31:16]});
      apb(1'b0, TSC_OFF_CMP, 32'h0);
      `CHK(rdat, {16'h0, seed[31:16]})
    end
    pin <= 1'b0;
    wr(TSC_OFF_CMP, 32'h5);
    for (int k = 0; k < 5; k++) begin
      v = (k < 4) ? {2'(k), 14'h0} : 16'h0800;
      if (k == 4) wr(TSC_OFF_CMP, 32'h0303);
      wr(TSC_OFF_MODE, {16'h0, v});
      wr(TSC_OFF_CMD, 32'h1);
      wait_sig(1'b0, t0);
      wait_sig(1'b0, t1);
      g0 = (k < 4) ? exp_gap(16'h5, 2'(k)) : exp_gap(16'h0003, 2'h0);
      `CHK(t1 - t0, g0)
      wr(TSC_OFF_CMD, 32'h2);
    end
    wr(TSC_OFF_CMP, 32'd40);
    for (int b = 0; b < 2; b++) begin
      wr(TSC_OFF_MODE, 32'(b));
      wr(TSC_OFF_CMD, 32'h1);
      cnt_irq(6, c);
      `CHK(c, b)
      wr(TSC_OFF_CMD, 32'h2);
    end
    wr(TSC_OFF_OUTCTL, 32'h1);
    wr(TSC_OFF_CMP, 32'h3);
    wr(TSC_OFF_MODE, 32'h0);
    wr(TSC_OFF_CMD, 32'h1);
    wait_sig(1'b0, t0);
    @(posedge clk);
    o = cout;
    wait_sig(1'b0, t0);
    @(posedge clk);
    `CHK(cout, ~o)
    ce <= 1'b0;
    cnt_irq(20, c);
    ce <= 1'b1;
    `CHK(c, 0)
    wait_sig(1'b0, t1);
    `CHK(t1 - t0, exp_gap(16'h3, 2'h0) + 20)
    wr(TSC_OFF_CMD, 32'h2);
    wr(TSC_OFF_OUTCTL, 32'h0);
    wr(TSC_OFF_OUTCTL, 32'h4);
    chk_out(1'b1);
    wr(TSC_OFF_OUTCTL, 32'h6);
    chk_out(1'b0);
    wr(TSC_OFF_OUTCTL, 32'h7);
    wr(TSC_OFF_OUTCTL, 32'h3);
    chk_out(1'b0);
    wr(TSC_OFF_OUTCTL, 32'h0);
    wr(TSC_OFF_OSTYLE, 32'h8);
    wr(TSC_OFF_OUTCTL, 32'h1);
    mper <= 16'd60;
    mgo <= 1'b1;
    for (int n = 7; n <= 12; n += 5) begin
      wr(TSC_OFF_CMP, 32'(n));
      wr(TSC_OFF_MODE, 32'h0409);
      wr(TSC_OFF_CMD, 32'h1);
      wait_sig(1'b1, t0);
      @(posedge clk);
      `CHK(cout, 1'b1)
      wait_sig(1'b0, t1);
      `CHK(t1 - t0, n + 1)
      sirq <= 1'b1;
      @(posedge clk);
      sirq <= 1'b0;
      chk_out(1'b0);
      wr(TSC_OFF_CMD, 32'h2);
    end
    mper <= 16'd6;
    wr(TSC_OFF_CMP, 32'd12);
    for (int m = 0; m < 3; m++) begin
      v = (m == 0) ? 16'h0409 : (m == 1) ? 16'h0408 : 16'h040c;
      wr(TSC_OFF_MODE, {16'h0, v});
      wr(TSC_OFF_CMD, 32'h1);
      wait_sig(1'b1, t0);
      wait_sig(1'b1, t0);
      cnt_irq(3, c);
      `CHK(c, int'(m == 0))
      wr(TSC_OFF_CMD, 32'h2);
    end
    mgo <= 1'b0;
    wr(TSC_OFF_CMP, 32'h2);
    for (int m = 0; m < 4; m++) begin
      v = (m == 0) ? 16'h1006 : (m == 1) ? 16'h0104 :
          (m == 2) ? 16'h0204 : 16'h010c;
      wr(TSC_OFF_MODE, {16'h0, v});
      wr(TSC_OFF_CMD, 32'h1);
      pulse_irqs(c);
      `CHK(c, (m == 0) ? 1 : (m == 2) ? 6 : 3)
      wr(TSC_OFF_CMD, 32'h2);
    end
    finish_test();
  end
endmodule
